/* design/irq_prio_pkg.sv */
`default_nettype none

package irq_prio_pkg;

  // Eight bytes, one per register group
  typedef logic [7:0][7:0] group_bytes_t;
  typedef logic [4:0][7:0] low_bytes_t;
  typedef logic [2:0][7:0] high_bytes_t;

  // Request pair toward the core
  typedef struct packed {
    logic high;
    logic low;
  } irq_req_t;

  typedef enum logic [2:0] {
    K_NONE = 3'b000,
    K_CFG  = 3'b001,
    K_FLAG = 3'b010,
    K_CTRL = 3'b011,
    K_STAT = 3'b100,
    K_MASK = 3'b101
  } reg_kind_t;

  typedef struct packed {
    reg_kind_t  kind;
    logic [2:0] grp;
  } reg_sel_t;

endpackage

`default_nettype wire

/* design/irq_prio_regs.svh */
`ifndef IRQ_PRIO_REGS_SVH
`define IRQ_PRIO_REGS_SVH

// Register indices; byte address is four times the index
`define IDX_PRIORITY_GROUP0 14'h0EB5
`define IDX_PRIORITY_GROUP1 14'h0EB6
`define IDX_PRIORITY_GROUP2 14'h0EB7
`define IDX_PRIORITY_GROUP3 14'h0EB8
`define IDX_PRIORITY_GROUP4 14'h0EB9
`define IDX_ENABLE_GROUP5   14'h0EC2
`define IDX_ENABLE_GROUP6   14'h0EC3
`define IDX_ENABLE_GROUP7   14'h0EC4
`define IDX_FLAG_BASE       14'h0ED0
`define IDX_CONTROL         14'h0EE0
`define IDX_IRQ_STATUS      14'h0EE1
`define IDX_IRQ_MASK        14'h0EE2

// Implemented bit positions per group
`define IMPL_GROUP0 8'h37
`define IMPL_GROUP1 8'hC3
`define IMPL_GROUP2 8'hC3
`define IMPL_GROUP3 8'hFF
`define IMPL_GROUP4 8'h3F
`define IMPL_GROUP5 8'hF7
`define IMPL_GROUP6 8'hF3
`define IMPL_GROUP7 8'hE1

// Reset values of the priority and enable registers
`define RESET_GROUP0 8'h31
`define RESET_GROUP1 8'hC3
`define RESET_GROUP2 8'hC3
`define RESET_GROUP3 8'h33
`define RESET_GROUP4 8'h3F
`define RESET_GROUP5 8'h00
`define RESET_GROUP6 8'h00
`define RESET_GROUP7 8'h00

// Field positions and bus answers
`define CTRL_GLOBAL_EN_BIT 0
`define STAT_HIGH_BIT      0
`define STAT_LOW_BIT       1
`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

/* design/periph_irq_enable_priority.sv */
// Summary of operation
// - enable_group5 bits 7..4 pass (1) or block (0) logic cells one to four.
// - enable_group5 bits 0..2 enable timer gates one, three, five; bit 3 absent.
// - enable_group6 bits 7..4 gate logic cells five to eight, bits 1..0 capcomp.
// - enable_group7 holds scan 7, checksum 6, nonvolatile 5, waveform gen 0.
// - every enable bit resets to zero so all covered sources start disabled.
// - a priority bit of one selects the high level and zero the low level.
// - priority_group0 maps timer0 5, pin change 4, ext pins 2..0; reset 0x31.
// - priority_group1 maps osc fail 7, clock switch 6, converter 1..0; all high.
// - priority_group2 maps voltage 7, zero cross 6, comparators 1..0; all high.
// - priority_group3 maps serial and sync port sources; unit one resets high.
// - priority_group4 maps timer match and overflow sources; all reset high.
// - a source flag is set by its event and stays until software clears it.
// - group 0 sources ignore the peripheral global enable bit.
`include "irq_prio_regs.svh"
`default_nettype none

module periph_irq_enable_priority (
  // Clock and reset
  input  wire logic                      aclk,
  input  wire logic                      aresetn,
  // AXI4-Lite write address and data
  input  wire logic                      awvalid,
  output logic                           awready,
  input  wire logic [15:0]               awaddr,
  input  wire logic                      wvalid,
  output logic                           wready,
  input  wire logic [31:0]               wdata,
  input  wire logic [3:0]                wstrb,
  // AXI4-Lite write response
  output logic                           bvalid,
  input  wire logic                      bready,
  output logic [1:0]                     bresp,
  // AXI4-Lite read
  input  wire logic                      arvalid,
  output logic                           arready,
  input  wire logic [15:0]               araddr,
  output logic                           rvalid,
  input  wire logic                      rready,
  output logic [31:0]                    rdata,
  output logic [1:0]                     rresp,
  // Source events, one byte per group
  input  wire irq_prio_pkg::group_bytes_t source_event,
  // Enables of groups 0..4 and priorities of groups 5..7 held elsewhere
  input  wire irq_prio_pkg::low_bytes_t   source_enable,
  input  wire irq_prio_pkg::high_bytes_t  source_prio,
  // Requests to the core and the bus interrupt
  output irq_prio_pkg::irq_req_t          core_req,
  output logic                           irq
);
  import irq_prio_pkg::*;

  localparam group_bytes_t IMPL = {
    `IMPL_GROUP7, `IMPL_GROUP6, `IMPL_GROUP5, `IMPL_GROUP4,
    `IMPL_GROUP3, `IMPL_GROUP2, `IMPL_GROUP1, `IMPL_GROUP0
  };
  localparam group_bytes_t RESET_CFG = {
    `RESET_GROUP7, `RESET_GROUP6, `RESET_GROUP5, `RESET_GROUP4,
    `RESET_GROUP3, `RESET_GROUP2, `RESET_GROUP1, `RESET_GROUP0
  };

  // Bus handshake state
  logic        aw_held;
  logic        next_aw_held;
  logic        w_held;
  logic        next_w_held;
  logic [15:0] waddr_q;
  logic [15:0] next_waddr_q;
  logic [7:0]  wbyte_q;
  logic [7:0]  next_wbyte_q;
  logic        wlane_q;
  logic        next_wlane_q;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;

  // Register file state
  group_bytes_t cfg;
  group_bytes_t next_cfg;
  group_bytes_t flag;
  group_bytes_t next_flag;
  logic         global_en;
  logic         next_global_en;
  logic [1:0]   stat;
  logic [1:0]   next_stat;
  logic [1:0]   mask;
  logic [1:0]   next_mask;

  // Request state
  irq_req_t next_core_req;
  logic     next_irq;

  // Shared decode results
  logic         do_write;
  logic         do_read;
  reg_sel_t     wsel;
  reg_sel_t     rsel;
  group_bytes_t eff_en;
  group_bytes_t eff_prio;
  group_bytes_t active;

  // Map a byte address to a register kind and group
  function automatic reg_sel_t decode(input logic [15:0] addr);
    reg_sel_t   s;
    logic [13:0] idx;
    s.kind = K_NONE;
    s.grp  = 3'h0;
    idx    = addr[15:2];
    case (idx)
      `IDX_PRIORITY_GROUP0: s = '{K_CFG, 3'h0};
      `IDX_PRIORITY_GROUP1: s = '{K_CFG, 3'h1};
      `IDX_PRIORITY_GROUP2: s = '{K_CFG, 3'h2};
      `IDX_PRIORITY_GROUP3: s = '{K_CFG, 3'h3};
      `IDX_PRIORITY_GROUP4: s = '{K_CFG, 3'h4};
      `IDX_ENABLE_GROUP5:   s = '{K_CFG, 3'h5};
      `IDX_ENABLE_GROUP6:   s = '{K_CFG, 3'h6};
      `IDX_ENABLE_GROUP7:   s = '{K_CFG, 3'h7};
      `IDX_CONTROL:         s = '{K_CTRL, 3'h0};
      `IDX_IRQ_STATUS:      s = '{K_STAT, 3'h0};
      `IDX_IRQ_MASK:        s = '{K_MASK, 3'h0};
      default: begin
        if (idx[13:3] == `IDX_FLAG_BASE >> 3) begin
          s = '{K_FLAG, idx[2:0]};
        end
      end
    endcase
    return s;
  endfunction

  // Ready is only offered while the matching slot is free
  assign awready  = ~aw_held & ~bvalid;
  assign wready   = ~w_held & ~bvalid;
  assign arready  = ~rvalid;
  assign do_write = aw_held & w_held & ~bvalid;
  assign do_read  = arvalid & arready;
  assign wsel     = decode(waddr_q);
  assign rsel     = decode(araddr);

  // Address and data are caught in either order, then applied together
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_waddr_q = waddr_q;
    next_wbyte_q = wbyte_q;
    next_wlane_q = wlane_q;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    next_rvalid  = rvalid;
    next_rdata   = rdata;
    next_rresp   = rresp;
    if (awvalid & awready) begin
      next_aw_held = 1'b1;
      next_waddr_q = awaddr;
    end
    if (wvalid & wready) begin
      next_w_held  = 1'b1;
      next_wbyte_q = wdata[7:0];
      next_wlane_q = wstrb[0];
    end
    if (bvalid & bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = (wsel.kind == K_NONE) ? `RESP_SLVERR : `RESP_OKAY;
    end
    if (rvalid & rready) begin
      next_rvalid = 1'b0;
    end
    // Narrow registers sit in the low byte, upper bits read zero
    if (do_read) begin
      next_rvalid = 1'b1;
      next_rresp  = `RESP_OKAY;
      next_rdata  = 32'h0000_0000;
      case (rsel.kind)
        K_CFG:  next_rdata[7:0] = cfg[rsel.grp] & IMPL[rsel.grp];
        K_FLAG: next_rdata[7:0] = flag[rsel.grp] & IMPL[rsel.grp];
        K_CTRL: next_rdata[`CTRL_GLOBAL_EN_BIT] = global_en;
        K_STAT: next_rdata[1:0] = stat;
        K_MASK: next_rdata[1:0] = mask;
        default: next_rresp = `RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      waddr_q <= 16'h0000;
      wbyte_q <= 8'h00;
      wlane_q <= 1'b0;
      bvalid  <= 1'b0;
      bresp   <= `RESP_OKAY;
      rvalid  <= 1'b0;
      rdata   <= 32'h0000_0000;
      rresp   <= `RESP_OKAY;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      waddr_q <= next_waddr_q;
      wbyte_q <= next_wbyte_q;
      wlane_q <= next_wlane_q;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
    end
  end

  // Register writes; only byte lane 0 carries data
  always_comb begin
    next_cfg       = cfg;
    next_flag      = flag;
    next_global_en = global_en;
    next_mask      = mask;
    next_stat      = stat;
    if (do_write & wlane_q) begin
      case (wsel.kind)
        K_CFG:  next_cfg[wsel.grp] = wbyte_q & IMPL[wsel.grp];
        K_FLAG: next_flag[wsel.grp] = wbyte_q & IMPL[wsel.grp];
        K_CTRL: next_global_en = wbyte_q[`CTRL_GLOBAL_EN_BIT];
        K_MASK: next_mask = wbyte_q[1:0];
        default: next_mask = mask; // Status is cleared by reading only
      endcase
    end
    // Events override a clearing write in the same cycle
    for (int g = 0; g < 8; g++) begin
      next_flag[g] = next_flag[g] | (source_event[g] & IMPL[g]);
    end
    // Reading the status clears it, but a new edge still lands
    if (do_read && rsel.kind == K_STAT) begin
      next_stat = 2'b00;
    end
    next_stat[`STAT_HIGH_BIT] = next_stat[`STAT_HIGH_BIT]
                                | (next_core_req.high & ~core_req.high);
    next_stat[`STAT_LOW_BIT]  = next_stat[`STAT_LOW_BIT]
                                | (next_core_req.low & ~core_req.low);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg       <= RESET_CFG;
      flag      <= '0;
      global_en <= 1'b0;
      mask      <= 2'b00;
      stat      <= 2'b00;
    end else begin
      cfg       <= next_cfg;
      flag      <= next_flag;
      global_en <= next_global_en;
      mask      <= next_mask;
      stat      <= next_stat;
    end
  end

  // Groups 5..7 keep their enables here, groups 0..4 their priorities
  assign eff_en   = {cfg[7:5], source_enable};
  assign eff_prio = {source_prio, cfg[4:0]};

  // Pending and enabled sources; group 0 bypasses the global enable
  always_comb begin
    for (int g = 0; g < 8; g++) begin
      active[g] = flag[g] & eff_en[g] & IMPL[g];
      if (g != 0 && !global_en) begin
        active[g] = 8'h00;
      end
    end
  end

  // Steer each live source to its level; registered to keep outputs clean
  always_comb begin
    next_core_req.high = |(active & eff_prio);
    next_core_req.low  = |(active & ~eff_prio);
    next_irq           = |(next_stat & next_mask);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      core_req <= '0;
      irq      <= 1'b0;
    end else begin
      core_req <= next_core_req;
      irq      <= next_irq;
    end
  end

endmodule

`default_nettype wire

/* verification/irq_prio_properties.sv */
`include "irq_prio_regs.svh"
`default_nettype none

module irq_prio_properties (
  // Clock and reset
  input wire logic                    aclk,
  input wire logic                    aresetn,
  // Register bus
  input wire logic                    awvalid,
  input wire logic                    awready,
  input wire logic                    wvalid,
  input wire logic                    wready,
  input wire logic                    bvalid,
  input wire logic                    bready,
  input wire logic [1:0]              bresp,
  input wire logic                    arvalid,
  input wire logic                    arready,
  input wire logic                    rvalid,
  input wire logic                    rready,
  input wire logic [31:0]             rdata,
  input wire logic [1:0]              rresp,
  // Core side
  input wire irq_prio_pkg::irq_req_t  core_req,
  input wire logic                    irq
);
  import irq_prio_pkg::*;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Answers stand until taken; holding payload avoids torn reads
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped");
  rdata_hold_a: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped");
  upper_zero_a: assert property (rvalid |-> rdata[31:8] == 24'h000000)
    else $error("upper read bits set");
  read_answer_a: assert property (arvalid && arready |=> rvalid)
    else $error("read not answered");
  write_answer_a: assert property (awvalid && awready && wvalid && wready
    |-> ##2 bvalid) else $error("write not answered");
  write_block_a: assert property (bvalid |-> !awready && !wready)
    else $error("write taken during answer");
  read_block_a: assert property (rvalid |-> !arready)
    else $error("read taken during answer");
  resp_code_a: assert property (rvalid |-> rresp == `RESP_OKAY
    || rresp == `RESP_SLVERR) else $error("bad read response");

  // Main scenarios
  write_c: cover property (bvalid && bready);
  high_c: cover property (core_req.high);
  low_c: cover property (core_req.low && irq);
endmodule

`default_nettype wire

/* verification/tb.sv */
`include "irq_prio_regs.svh"
`default_nettype none

module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import irq_prio_pkg::*;

  logic         aclk = 1'b0;
  logic         aresetn = 1'b0;
  logic         awvalid = 1'b0;
  logic         wvalid = 1'b0;
  logic         bready = 1'b0;
  logic         arvalid = 1'b0;
  logic         rready = 1'b0;
  logic [15:0]  awaddr = 16'h0000;
  logic [15:0]  araddr = 16'h0000;
  logic [31:0]  wdata = 32'h00000000;
  logic [3:0]   wstrb = 4'h0;
  logic         awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]   bresp, rresp;
  logic [31:0]  rdata;
  group_bytes_t ev = '0;
  low_bytes_t   sen = '0;
  high_bytes_t  spr = '0;
  irq_req_t     core_req;
  int           failures = 0;
  int           comparisons = 0;
  logic [13:0]  rix [8] = '{`IDX_PRIORITY_GROUP0, `IDX_PRIORITY_GROUP1,
    `IDX_PRIORITY_GROUP2, `IDX_PRIORITY_GROUP3, `IDX_PRIORITY_GROUP4,
    `IDX_ENABLE_GROUP5, `IDX_ENABLE_GROUP6, `IDX_ENABLE_GROUP7};
  logic [7:0]   rst [8] = '{`RESET_GROUP0, `RESET_GROUP1, `RESET_GROUP2,
    `RESET_GROUP3, `RESET_GROUP4, `RESET_GROUP5, `RESET_GROUP6, `RESET_GROUP7};
  logic [7:0]   imp [8] = '{`IMPL_GROUP0, `IMPL_GROUP1, `IMPL_GROUP2,
    `IMPL_GROUP3, `IMPL_GROUP4, `IMPL_GROUP5, `IMPL_GROUP6, `IMPL_GROUP7};

  periph_irq_enable_priority uut (
    .aclk, .aresetn, .awvalid, .awready, .awaddr, .wvalid, .wready, .wdata,
    .wstrb, .bvalid, .bready, .bresp, .arvalid, .arready, .araddr, .rvalid,
    .rready, .rdata, .rresp, .source_event(ev), .source_enable(sen),
    .source_prio(spr), .core_req, .irq);

  // 125 MHz
  always #4 aclk = ~aclk;

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // Each half is released as soon as it is taken; the slave may split them
  // Ready is judged at the falling edge so the taking edge is not raced
  task automatic wr(input logic [13:0] ix, input logic [7:0] d,
                    input logic [1:0] er, input logic [3:0] st = 4'hF);
    logic a, w, ta, tw;
    a = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    awaddr <= {ix, 2'b00};
    wdata <= {24'h000000, d};
    wstrb <= st;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(a && w)) begin
      @(negedge aclk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      @(posedge aclk);
      if (ta) begin
        a = 1'b1;
        awvalid <= 1'b0;
      end
      if (tw) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    do @(negedge aclk); while (!bvalid);
    chk(32'(bresp), 32'(er));
    @(posedge aclk);
    bready <= 1'b0;
  endtask

  task automatic rd(input logic [13:0] ix, input logic [7:0] ed,
                    input logic [1:0] er);
    @(posedge aclk);
    araddr <= {ix, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(negedge aclk); while (!arready);
    @(posedge aclk);
    arvalid <= 1'b0;
    do @(negedge aclk); while (!rvalid);
    chk(rdata, {24'h000000, ed});
    chk(32'(rresp), 32'(er));
    @(posedge aclk);
    rready <= 1'b0;
  endtask

  task automatic finish_test;
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Roughly 24 loops of seven bus transfers; a hang is cut well beyond that
  initial begin
    #200000;
    failures++;
    finish_test();
  end

  // Reset, register map, then random source routing
  initial begin : main
    logic [7:0] d;
    int         g, b;
    logic       en, pr, gl, req;
    logic [1:0] mk;
    void'($urandom(88));
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 8; i++) rd(rix[i], rst[i], `RESP_OKAY);
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 8'hFF : 8'($urandom);
      wr(rix[i], d, `RESP_OKAY);
      rd(rix[i], d & imp[i], `RESP_OKAY);
    end
    // A write with lane 0 off must leave the register alone
    wr(rix[0], 8'h00, `RESP_OKAY, 4'h0);
    rd(rix[0], imp[0], `RESP_OKAY);
    wr(14'h0100, 8'hFF, `RESP_SLVERR);
    rd(14'h0100, 8'h00, `RESP_SLVERR);
    $display("register map done");
    // First pass is a group 0 source with the global enable off
    for (int n = 0; n < 24; n++) begin
      g = (n == 0) ? 0 : int'($urandom % 8);
      do b = int'($urandom % 8); while (!imp[g][b]);
      en = (n == 0) | 1'($urandom);
      pr = 1'($urandom);
      gl = (n != 0) & 1'($urandom);
      mk = 2'($urandom);
      wr(`IDX_CONTROL, {7'h00, gl}, `RESP_OKAY);
      wr(`IDX_IRQ_MASK, {6'h00, mk}, `RESP_OKAY);
      if (g < 5) begin
        sen[g] <= 8'(en) << b;
        wr(rix[g], 8'(pr) << b, `RESP_OKAY);
      end else begin
        spr[g-5] <= 8'(pr) << b;
        wr(rix[g], 8'(en) << b, `RESP_OKAY);
      end
      @(posedge aclk);
      ev[g][b] <= 1'b1;
      @(posedge aclk);
      ev[g][b] <= 1'b0;
      repeat (3) @(posedge aclk);
      @(negedge aclk);
      req = en & (gl | (g == 0));
      chk(32'(core_req), 32'({req & pr, req & ~pr}));
      chk(32'(irq), 32'(|({req & ~pr, req & pr} & mk)));
      rd(`IDX_FLAG_BASE + 14'(g), 8'h01 << b, `RESP_OKAY);
      rd(`IDX_IRQ_STATUS, {6'h00, req & ~pr, req & pr}, `RESP_OKAY);
      rd(`IDX_IRQ_STATUS, 8'h00, `RESP_OKAY);
      wr(`IDX_FLAG_BASE + 14'(g), 8'h00, `RESP_OKAY);
      repeat (2) @(posedge aclk);
      @(negedge aclk);
      chk(32'(core_req), 32'h00000000);
      chk(32'(irq), 32'h00000000);
    end
    $display("request routing done");
    finish_test();
  end
endmodule

bind periph_irq_enable_priority irq_prio_properties props (
  .aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
  .bresp, .arvalid, .arready, .rvalid, .rready, .rdata, .rresp, .core_req,
  .irq);

`default_nettype wire
